// ===== bfs_boot_assertions.sv
`timescale 1ns/1ns
module bfs_boot_assertions
   import bfs_pkg::*;
#(
   parameter int IMG_BYTES = 65536
) (
   // system
   input wire logic       sys_clk,
   input wire logic       reset_n,
   input wire logic       por_done,
   // flash link
   input wire logic       q_sck,
   input wire logic       q_cs_n,
   input wire logic [3:0] q_oe,
   // command, image and status
   input wire logic       cmd_valid,
   input wire logic       cmd_ready,
   input wire logic       img_valid,
   input wire logic       boot_done,
   input wire logic       boot_slave,
   input wire logic       spi_miso_oe
);
   logic [31:0] img_cnt_q;

   // counts image bytes since reset so completion can be tied to the length
   always_ff @(posedge sys_clk) begin
      if (!reset_n || !por_done) img_cnt_q <= 32'h0;
      else if (img_valid) img_cnt_q <= img_cnt_q + 32'h1;
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence s_taken;
      cmd_valid && cmd_ready;
   endsequence
   sequence s_sck_high;
      q_sck [*2] ##1 !q_sck;
   endsequence

   chk_reset_quiet: assert property (disable iff (!por_done)
      !reset_n [*4] |-> q_cs_n && q_oe == OE_OFF && !boot_done && !cmd_ready)
      else $error("outputs active in reset");
   chk_por_quiet: assert property (!por_done [*4] |->
      q_cs_n && q_oe == OE_OFF && !boot_done && !cmd_ready)
      else $error("outputs active in power-on reset");
   chk_sck_half: assert property ($rose(q_sck) |-> s_sck_high)
      else $error("flash clock high phase wrong");
   chk_cs_sck_low: assert property ($fell(q_cs_n) |-> !q_sck)
      else $error("frame opened with clock high");
   chk_oe_between: assert property (q_cs_n |-> q_oe == OE_OFF)
      else $error("flash lines driven between frames");
   chk_slave_quiet: assert property (boot_slave |-> !cmd_ready && q_cs_n)
      else $error("flash master active in slave boot");
   chk_miso_enable: assert property (boot_done |-> spi_miso_oe == boot_slave)
      else $error("slave output enable wrong");
   chk_strap_held: assert property (boot_done |=> $stable(boot_slave))
      else $error("boot mode changed");
   chk_done_count: assert property ($rose(boot_done) |->
      img_cnt_q + 32'(img_valid) == IMG_BYTES)
      else $error("boot done at wrong byte count");
   chk_cmd_start: assert property (s_taken |=> !cmd_ready ##[1:6] $fell(q_cs_n))
      else $error("command did not open a frame");
endmodule // bfs_boot_assertions

bind bfs_boot_seq bfs_boot_assertions #(.IMG_BYTES(IMG_BYTES)) chk_i (.*);

// ===== bfs_boot_seq.sv
`timescale 1ns/1ns
module bfs_boot_seq
   import bfs_pkg::*;
#(
   parameter int          IMG_BYTES = 65536,
   parameter logic [23:0] UPD_ADDR  = UPDATE_ADDR
) (
   // system
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        por_done,
   // quad flash link, q_di[1] doubles as boot_select_strap
   output logic             q_sck,
   output logic             q_cs_n,
   output logic [3:0]       q_do,
   output logic [3:0]       q_oe,
   input  wire logic [3:0]  q_di,
   // slave boot link
   input  wire logic        spi_clk,
   input  wire logic        spi_cs_n,
   input  wire logic        spi_mosi,
   output logic             spi_miso,
   output logic             spi_miso_oe,
   // command port
   input  wire logic        cmd_valid,
   input  wire logic [2:0]  cmd_code,
   input  wire logic [23:0] cmd_addr,
   input  wire logic [8:0]  cmd_len,
   input  wire logic [7:0]  cmd_data,
   output logic             cmd_ready,
   // page buffer fill
   input  wire logic        pbuf_we,
   input  wire logic [7:0]  pbuf_addr,
   input  wire logic [7:0]  pbuf_data,
   // image and status
   output logic             img_valid,
   output logic [7:0]       img_byte,
   output logic             boot_done,
   output logic             boot_slave,
   output logic [23:0]      flash_id,
   output logic [7:0]       flash_status
);

   bfs_state_e  st_q, ret_q;
   logic        rn_s1, rn_s2, rst;
   logic [3:0]  di_s1, di_s2;
   logic [2:0]  wait_q;
   logic [2:0]  c_code_q;
   logic [23:0] c_addr_q;
   logic [8:0]  c_len_q;
   logic [7:0]  c_data_q;
   logic        xgo_q, xna_q, xnd_q, xrd_q, xquad_q, xsrc_q;
   logic [7:0]  xop_q;
   logic [23:0] xaddr_q, xlen_q;
   logic [7:0]  l_op;
   logic [23:0] l_addr, l_len;
   logic        l_na, l_nd, l_rd, l_quad, l_src, launch;
   logic        busy_q, rxv_q;
   logic [7:0]  div_q, sh_q, rx_q, rxb_q, nxt_tx, rx_nxt, mem_q;
   logic [2:0]  bit_q;
   logic [24:0] pos_q, hdr, total, np, didx;
   logic [3:0]  nxt_oe;
   logic        tick, quad_now, last_bit;
   logic [2:0]  sl_bit_q;
   logic [6:0]  sl_sh_q;
   logic [7:0]  sl_hold_q;
   logic        sl_tgl_q, tg_s1, tg_s2, tg_s3, sl_ev;
   logic [23:0] sl_cnt_q;
   logic [8:0]  pp_len;

   function automatic logic [3:0] pin_out(input logic [7:0] s, input logic q);
      pin_out = q ? s[3:0] : {3'b110, s[7]};
   endfunction

   function automatic logic [7:0] shift_out(input logic [7:0] s, input logic q);
      shift_out = q ? {4'h0, s[7:4]} : {s[6:0], 1'b0};
   endfunction

   // reset pin and power-on level both pass two flops; no clock enable needed
   always_ff @(posedge sys_clk) begin
      rn_s1 <= reset_n & por_done;
      rn_s2 <= rn_s1;
      di_s1 <= q_di;
      di_s2 <= di_s1;
      tg_s1 <= sl_tgl_q;
      tg_s2 <= tg_s1;
   end
   assign rst   = ~rn_s2;
   assign sl_ev = tg_s2 ^ tg_s3;

   // slave link domain: frame state is cleared by chip select itself
   always_ff @(posedge spi_clk or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         sl_bit_q <= 3'h0;
         sl_sh_q  <= 7'h00;
         spi_miso <= 1'b0;
      end else begin
         sl_bit_q <= sl_bit_q + 3'h1;
         sl_sh_q  <= {spi_mosi, sl_sh_q[6:1]};
         spi_miso <= spi_mosi;
      end
   end

   // held byte stays still for eight link clocks after each toggle
   always_ff @(posedge spi_clk or negedge reset_n) begin
      if (!reset_n) begin
         sl_hold_q <= 8'h00;
         sl_tgl_q  <= 1'b0;
      end else if (!spi_cs_n && sl_bit_q == 3'h7) begin
         sl_hold_q <= {spi_mosi, sl_sh_q};
         sl_tgl_q  <= ~sl_tgl_q;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tg_s3 <= 1'b0;
      end else begin
         tg_s3 <= tg_s2;
      end
   end

   // launch fields per state
   always_comb begin
      pp_len = (cmd_len_q_zero() || c_len_q > 9'(PAGE_BYTES)) ? 9'(PAGE_BYTES) : c_len_q;
      l_op   = OP_WRITE_EN;
      l_addr = 24'h000000;
      l_len  = 24'h000000;
      l_na   = 1'b0;
      l_nd   = 1'b0;
      l_rd   = 1'b0;
      l_quad = 1'b0;
      l_src  = 1'b0;
      launch = 1'b0;
      unique case (st_q)
         S_BOOT: begin
            l_op   = OP_QUAD_READ;
            l_addr = BOOT_ADDR;
            l_na   = 1'b1;
            l_nd   = 1'(QREAD_DUMMY);
            l_len  = 24'(IMG_BYTES);
            l_rd   = 1'b1;
            l_quad = 1'b1;
            launch = 1'b1;
         end
         S_IDLE: begin
            launch = cmd_valid & cmd_ready;
            if (cmd_code == CMD_READ_ID) begin
               l_op  = OP_READ_ID;
               l_nd  = 1'(ID_DUMMY);
               l_len = 24'(ID_BYTES);
               l_rd  = 1'b1;
            end else if (cmd_code == CMD_WRITE_DIS) begin
               l_op = OP_WRITE_DIS;
            end else begin
               l_op = OP_WRITE_EN;
            end
         end
         S_OP: begin
            launch = 1'b1;
            l_na   = 1'b1;
            if (c_code_q == CMD_PROGRAM) begin
               l_op   = OP_PAGE_PROG;
               l_addr = {c_addr_q[23:8] , 8'h00} & ADDR_MASK;
               l_len  = {15'h0000, pp_len};
            end else if (c_code_q == CMD_WRITE_STATUS) begin
               l_op  = OP_WRITE_STATUS;
               l_na  = 1'b0;
               l_len = 24'h000001;
               l_src = 1'b1;
            end else if (c_code_q == CMD_ERASE) begin
               l_op   = OP_SECTOR_ERASE;
               l_addr = {c_addr_q[23:12], 12'h000} & ADDR_MASK;
            end else begin
               l_op   = OP_SECTOR_ERASE;
               l_addr = UPD_ADDR;
            end
         end
         S_POLL: begin
            l_op   = OP_READ_STATUS;
            l_len  = 24'h000001;
            l_rd   = 1'b1;
            launch = 1'b1;
         end
         default: begin
            launch = 1'b0;
         end
      endcase
   end

   function automatic logic cmd_len_q_zero();
      cmd_len_q_zero = (c_len_q == 9'h000);
   endfunction

   // sequencer
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q       <= S_SYNC;
         ret_q      <= S_IDLE;
         wait_q     <= 3'h0;
         boot_slave <= 1'b0;
         boot_done  <= 1'b0;
         cmd_ready  <= 1'b0;
         sl_cnt_q   <= 24'h000000;
         c_code_q   <= CMD_READ_ID;
         c_addr_q   <= 24'h000000;
         c_len_q    <= 9'h000;
         c_data_q   <= 8'h00;
      end else begin
         unique case (st_q)
            S_SYNC: begin
               wait_q <= wait_q + 3'h1;
               if (wait_q == SYNC_WAIT) begin
                  st_q <= S_STRAP;
               end
            end
            S_STRAP: begin
               boot_slave <= di_s2[1];
               st_q       <= di_s2[1] ? S_SLAVE : S_BOOT;
            end
            S_BOOT: begin
               ret_q <= S_DONE;
               st_q  <= S_WAIT;
            end
            S_WAIT: begin
               if (!xgo_q && !busy_q) begin
                  st_q <= ret_q;
               end
            end
            S_DONE: begin
               boot_done <= 1'b1;
               cmd_ready <= 1'b1;
               st_q      <= S_IDLE;
            end
            S_SLAVE: begin
               if (sl_ev) begin
                  sl_cnt_q <= sl_cnt_q + 24'h000001;
                  if (sl_cnt_q == 24'(IMG_BYTES - 1)) begin
                     boot_done <= 1'b1;
                     st_q      <= S_HALT;
                  end
               end
            end
            S_HALT: begin
               st_q <= S_HALT;
            end
            S_IDLE: begin
               if (launch) begin
                  cmd_ready <= 1'b0;
                  c_code_q  <= cmd_code;
                  c_addr_q  <= cmd_addr;
                  c_len_q   <= cmd_len;
                  c_data_q  <= cmd_data;
                  st_q      <= S_WAIT;
                  if (cmd_code == CMD_READ_ID || cmd_code == CMD_WRITE_DIS) begin
                     ret_q <= S_DONE;
                  end else begin
                     ret_q <= S_OP;
                  end
               end
            end
            S_OP: begin
               ret_q <= S_POLL;
               st_q  <= S_WAIT;
            end
            S_POLL: begin
               ret_q <= S_CHK;
               st_q  <= S_WAIT;
            end
            S_CHK: begin
               st_q <= ((flash_status & SR_BUSY_MASK) != 8'h00) ? S_POLL : S_DONE;
            end
         endcase
      end
   end

   // transfer descriptor handed to the serial engine
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         xgo_q   <= 1'b0;
         xop_q   <= OP_WRITE_EN;
         xaddr_q <= 24'h000000;
         xlen_q  <= 24'h000000;
         xna_q   <= 1'b0;
         xnd_q   <= 1'b0;
         xrd_q   <= 1'b0;
         xquad_q <= 1'b0;
         xsrc_q  <= 1'b0;
      end else begin
         xgo_q <= launch;
         if (launch) begin
            xop_q   <= l_op;
            xaddr_q <= l_addr;
            xlen_q  <= l_len;
            xna_q   <= l_na;
            xnd_q   <= l_nd;
            xrd_q   <= l_rd;
            xquad_q <= l_quad;
            xsrc_q  <= l_src;
         end
      end
   end

   // byte engine helpers
   assign hdr      = 25'h1 + (xna_q ? 25'(ADDR_BYTES) : 25'h0) + {24'h0, xnd_q};
   assign total    = hdr + {1'b0, xlen_q};
   assign np       = pos_q + 25'h1;
   assign didx     = np - hdr;
   assign tick     = (div_q == 8'(SCK_HALF - 1));
   assign quad_now = xquad_q && (pos_q != 25'h0);
   assign last_bit = (bit_q == (quad_now ? 3'h1 : 3'h7));
   assign rx_nxt   = quad_now ? {di_s2, rx_q[7:4]} : {rx_q[6:0], di_s2[1]};

   always_comb begin
      if (xna_q && np <= 25'(ADDR_BYTES)) begin
         unique case (np[1:0])
            2'h1:    nxt_tx = xaddr_q[23:16];
            2'h2:    nxt_tx = xaddr_q[15:8];
            default: nxt_tx = xaddr_q[7:0];
         endcase
      end else if (np < hdr) begin
         nxt_tx = DUMMY_BYTE;
      end else begin
         nxt_tx = xsrc_q ? c_data_q : mem_q;
      end
      if (!xquad_q) begin
         nxt_oe = OE_SINGLE;
      end else if (np >= hdr && xrd_q) begin
         nxt_oe = OE_OFF;
      end else begin
         nxt_oe = OE_QUAD_OUT;
      end
   end

   // serial engine: mode 0, data shifted on falling edge
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         busy_q <= 1'b0;
         q_cs_n <= 1'b1;
         q_sck  <= 1'b0;
         q_do   <= 4'h0;
         q_oe   <= OE_OFF;
         div_q  <= 8'h00;
         bit_q  <= 3'h0;
         pos_q  <= 25'h0;
         sh_q   <= 8'h00;
         rx_q   <= 8'h00;
         rxv_q  <= 1'b0;
         rxb_q  <= 8'h00;
      end else begin
         rxv_q <= 1'b0;
         if (xgo_q && !busy_q) begin
            busy_q <= 1'b1;
            q_cs_n <= 1'b0;
            div_q  <= 8'h00;
            bit_q  <= 3'h0;
            pos_q  <= 25'h0;
            sh_q   <= xop_q;
            q_do   <= pin_out(xop_q, 1'b0);
            q_oe   <= OE_SINGLE;
         end else if (busy_q) begin
            div_q <= tick ? 8'h00 : div_q + 8'h01;
            if (tick && !q_sck) begin
               q_sck <= 1'b1;
            end else if (tick) begin
               q_sck <= 1'b0;
               rx_q  <= rx_nxt;
               if (!last_bit) begin
                  bit_q <= bit_q + 3'h1;
                  sh_q  <= shift_out(sh_q, quad_now);
                  q_do  <= pin_out(shift_out(sh_q, quad_now), quad_now);
               end else begin
                  bit_q <= 3'h0;
                  if (pos_q >= hdr && xrd_q) begin
                     rxv_q <= 1'b1;
                     rxb_q <= rx_nxt;
                  end
                  if (np == total) begin
                     busy_q <= 1'b0;
                     q_cs_n <= 1'b1;
                     q_oe   <= OE_OFF;
                  end else begin
                     pos_q <= np;
                     sh_q  <= nxt_tx;
                     q_do  <= pin_out(nxt_tx, xquad_q);
                     q_oe  <= nxt_oe;
                  end
               end
            end
         end
      end
   end

   // image stream, id and status capture
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         img_valid    <= 1'b0;
         img_byte     <= 8'h00;
         flash_id     <= 24'h000000;
         flash_status <= 8'h00;
         spi_miso_oe  <= 1'b0;
      end else begin
         img_valid   <= 1'b0;
         spi_miso_oe <= boot_slave;
         if (rxv_q && xop_q == OP_QUAD_READ) begin
            img_valid <= 1'b1;
            img_byte  <= rxb_q;
         end else if (sl_ev && st_q == S_SLAVE) begin
            img_valid <= 1'b1;
            img_byte  <= sl_hold_q;
         end
         if (rxv_q && xop_q == OP_READ_ID) begin
            flash_id <= {flash_id[15:0], rxb_q};
         end
         if (rxv_q && xop_q == OP_READ_STATUS) begin
            flash_status <= rxb_q;
         end
      end
   end

   bfs_page_mem #(
      .WIDTH (8),
      .DEPTH (PAGE_BYTES),
      .AW    (8)
   ) u_pbuf (
      .clk     (sys_clk),
      .wr_en   (pbuf_we),
      .wr_addr (pbuf_addr),
      .wr_data (pbuf_data),
      .rd_addr (didx[7:0]),
      .rd_data (mem_q)
   );

endmodule // bfs_boot_seq

// ===== bfs_flash_model.sv
`timescale 1ns/1ns
module bfs_flash_model
   import bfs_pkg::*;
#(
   parameter logic [23:0] ID = 24'h5A3C96 // arbitrary id value
) (
   // sequencer side of the quad link
   input  wire logic       q_sck,
   input  wire logic       q_cs_n,
   input  wire logic [3:0] q_do,
   input  wire logic [3:0] q_oe,
   output logic      [3:0] q_di,
   // board pull on data line one
   input  wire logic       strap_hi
);
   logic [7:0]  ops[$];
   logic [7:0]  op = 8'h0;
   logic [7:0]  v;
   logic [7:0]  dat = 8'h0;
   logic [23:0] adr = 24'h0;
   logic [23:0] sav = 24'h0;
   logic [3:0]  drv = 4'h0;
   logic        doe = 1'h0;
   logic        wel = 1'h0;
   int          n = 0, cnt = 0, busy = 0, errs = 0, k;

   always @(negedge q_cs_n) begin
      n = 0;
      adr = 24'h0;
   end

   always @(posedge q_sck) if (!q_cs_n) begin
      if (n < 8) op = {op[6:0], q_do[0]};
      else if (op == OP_QUAD_READ && n < 14) adr = {adr[19:0], q_do};
      else if (op != OP_QUAD_READ && n < 32) adr = {adr[22:0], q_do[0]};
      else if (n < 40) dat = {dat[6:0], q_do[0]};
      n++;
   end

   // answer moves after the falling edge so it is settled at the next rise
   always @(negedge q_sck) if (!q_cs_n) begin
      k = n - 16;
      v = 8'(adr + 24'(k / 2)) ^ 8'h5A;
      doe = 1'h1;
      if (op == OP_READ_ID && n >= 8 && n < 32) drv = {2'h0, ID[31 - n], 1'h0};
      else if (op == OP_READ_STATUS && n >= 8) drv = {2'h0, 1'(n % 8 == 7 && busy > 0), 1'h0};
      else if (op == OP_QUAD_READ && n >= 16) drv = k[0] ? v[7:4] : v[3:0];
      else doe = 1'h0;
   end

   always @(posedge q_cs_n) begin
      ops.push_back(op);
      doe = 1'h0;
      if (op != OP_READ_STATUS) begin
         sav = adr;
         cnt = n;
      end
      else if (busy > 0) busy--;
      if (op inside {OP_SECTOR_ERASE, OP_PAGE_PROG, OP_WRITE_STATUS}) begin
         errs += wel ? 0 : 1;
         busy = 2;
      end
      wel = op == OP_WRITE_EN;
   end

   // released lines: line one follows the board pull, the rest show stale inverted data
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (q_oe[i]) q_di[i] = q_do[i];
         else if (doe && !q_cs_n) q_di[i] = drv[i];
         else if (i == 1) q_di[i] = strap_hi;
         else q_di[i] = !drv[i];
      end
   end
endmodule // bfs_flash_model

// ===== bfs_page_mem.sv
`timescale 1ns/1ns
module bfs_page_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 256,
   parameter int AW    = 8
) (
   // clock
   input  wire logic             clk,
   // write port
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   // read port
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      rd_data <= mem[rd_addr];
   end

endmodule // bfs_page_mem

// ===== bfs_pkg.sv
package bfs_pkg;

   // timing
   localparam int SYS_CLK_MHZ = 125;
   localparam int SCK_MAX_MHZ = 50;
   localparam int SCK_HALF    = (SYS_CLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
   localparam logic [2:0] SYNC_WAIT = 3'h3;

   // flash geometry
   localparam int PAGE_BYTES    = 256;
   localparam int PAGE_COUNT    = 8192;
   localparam int SECTOR_BYTES  = 4096;
   localparam int ADDR_BYTES    = 3;
   localparam int ID_BYTES      = 3;
   localparam int ID_DUMMY      = 0;
   localparam int QREAD_DUMMY   = 1;
   localparam logic [23:0] ADDR_MASK   = 24'(PAGE_BYTES * PAGE_COUNT - 1);
   localparam logic [23:0] BOOT_ADDR   = 24'h000000;
   localparam logic [23:0] UPDATE_ADDR = 24'h100000;

   // opcodes
   localparam logic [7:0] OP_READ_ID      = 8'h9F;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_WRITE_EN     = 8'h06;
   localparam logic [7:0] OP_WRITE_DIS    = 8'h04;
   localparam logic [7:0] OP_PAGE_PROG    = 8'h02;
   localparam logic [7:0] OP_QUAD_READ    = 8'hEB;
   localparam logic [7:0] OP_READ_STATUS  = 8'h05;
   localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
   localparam logic [7:0] SR_BUSY_MASK    = 8'h01;
   localparam logic [7:0] DUMMY_BYTE      = 8'hFF;

   // command port codes
   localparam logic [2:0] CMD_READ_ID      = 3'h0;
   localparam logic [2:0] CMD_ERASE        = 3'h1;
   localparam logic [2:0] CMD_PROGRAM      = 3'h2;
   localparam logic [2:0] CMD_WRITE_STATUS = 3'h3;
   localparam logic [2:0] CMD_WRITE_DIS    = 3'h4;
   localparam logic [2:0] CMD_REMOVE_UPD   = 3'h5;
   localparam logic [2:0] CMD_UPDATE_FAIL  = 3'h6;

   // quad pin enables: single mode keeps data lines 2 and 3 driven high
   localparam logic [3:0] OE_SINGLE   = 4'hD;
   localparam logic [3:0] OE_QUAD_OUT = 4'hF;
   localparam logic [3:0] OE_OFF      = 4'h0;

   typedef enum logic [3:0] {
      S_SYNC, S_STRAP, S_BOOT, S_WAIT, S_DONE, S_SLAVE, S_HALT,
      S_IDLE, S_OP, S_POLL, S_CHK
   } bfs_state_e;

endpackage

// ===== boot_flash_sequencer_bench.sv
`timescale 1ns/1ns
module boot_flash_sequencer_bench
   import bfs_pkg::*;
;
   localparam int          IMG = 8;
   localparam logic [23:0] ID  = 24'h5A3C96; // arbitrary id value
   logic        sys_clk = '0, reset_n = '0, por_done = '1, strap_hi = '0, spi_clk = '0;
   logic        spi_cs_n = '1, spi_mosi = '0, cmd_valid = '0, pbuf_we = '0;
   logic        q_sck, q_cs_n, spi_miso, spi_miso_oe, cmd_ready, img_valid, boot_done;
   logic        boot_slave;
   logic [3:0]  q_do, q_oe, q_di;
   logic [2:0]  cmd_code = '0;
   logic [8:0]  cmd_len = '0;
   logic [23:0] cmd_addr = '0, flash_id;
   logic [7:0]  cmd_data = '0, pbuf_addr = '0, pbuf_data = '0, img_byte, flash_status;
   logic [7:0]  got[$];
   int          miscompares = 0, samples_checked = 0;

   bfs_boot_seq #(.IMG_BYTES(IMG)) dut (.*);
   bfs_flash_model #(.ID(ID)) fl (.*);

   initial forever #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (img_valid === 1'h1) got.push_back(img_byte);

   task automatic results();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, e, input string m);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask

   // bounded wait on cmd_ready or boot_done
   task automatic wt(input bit rdy);
      int k = 0;
      while ((rdy ? cmd_ready : boot_done) !== 1'h1 && k < 20000) begin
         @(posedge sys_clk);
         k++;
      end
      if (k == 20000) begin
         miscompares++;
         results();
      end
   endtask

   // por selects the power-on level instead of the reset pin
   task automatic rst(input logic s, input bit por);
      @(posedge sys_clk);
      strap_hi <= s;
      if (por) por_done <= '0;
      else reset_n <= '0;
      repeat (12) @(posedge sys_clk);
      reset_n <= '1;
      por_done <= '1;
      got.delete();
   endtask

   task automatic cmd(input logic [2:0] c, input logic [23:0] a, input logic [8:0] l,
                      input logic [7:0] d);
      wt(1);
      fl.ops.delete();
      cmd_valid <= '1;
      cmd_code <= c;
      cmd_addr <= a;
      cmd_len <= l;
      cmd_data <= d;
      @(posedge sys_clk);
      cmd_valid <= '0;
      @(posedge sys_clk);
      wt(1);
   endtask

   task automatic chk_wr(input logic [7:0] op, input logic [23:0] a, input string m);
      logic [7:0] e[5] = '{OP_WRITE_EN, op, OP_READ_STATUS, OP_READ_STATUS, OP_READ_STATUS};
      chk(fl.ops.size(), 5, m);
      for (int i = 0; i < 5; i++) chk(fl.ops[i], e[i], m);
      chk(fl.sav, a, m);
      chk(fl.errs, 0, m);
      chk(flash_status, 8'h0, m);
   endtask

   task automatic t_slave();
      rst(1'h1, 1'b0);
      repeat (20) @(posedge sys_clk);
      strap_hi <= '0; // strap moves after latching and must be ignored
      #1 spi_cs_n = '0;
      for (int b = 0; b < IMG; b++) begin
         for (int i = 0; i < 8; i++) begin
            spi_mosi = 1'((8'(b) ^ 8'hC3) >> i);
            #3 spi_clk = '1;
            #3 spi_clk = '0;
            chk(spi_miso, spi_mosi, "miso echo");
         end
         #30;
      end
      spi_cs_n = '1;
      spi_mosi = ~spi_mosi;
      wt(0);
      // last byte is pushed at the edge where done is first seen
      @(posedge sys_clk);
      chk(spi_miso, 1'b0, "miso idle");
      chk(boot_slave, 1, "slave latch");
      chk(spi_miso_oe, 1, "miso enable");
      chk(q_oe, OE_OFF, "flash lines");
      for (int i = 0; i < IMG; i++) chk(got[i], 8'(i) ^ 8'hC3, "slave byte");
      $display("test slave boot ended");
   endtask

   task automatic t_quad(input bit por);
      fl.ops.delete();
      rst(1'h0, por);
      chk(boot_done, 0, "boot restarted");
      wt(0);
      chk(boot_slave, 0, "quad latch");
      chk(fl.ops[0], OP_QUAD_READ, "boot op");
      chk(fl.sav, BOOT_ADDR, "boot addr");
      for (int i = 0; i < IMG; i++) chk(got[i], 8'(i) ^ 8'h5A, "quad byte");
      $display("test quad boot ended");
   endtask

   task automatic t_id();
      cmd(CMD_READ_ID, 24'h0, 9'h0, 8'h0);
      chk(fl.ops[0], OP_READ_ID, "id op");
      chk(fl.cnt, 32, "id clocks");
      chk(flash_id, ID, "id");
      $display("test identify ended");
   endtask

   task automatic t_erase();
      cmd(CMD_ERASE, 24'h012345, 9'h0, 8'h0);
      chk_wr(OP_SECTOR_ERASE, 24'h012000, "erase");
      $display("test erase ended");
   endtask

   task automatic t_prog(input logic [8:0] l, input logic [23:0] a, e);
      for (int i = 0; i < 4; i++) begin
         pbuf_we <= '1;
         pbuf_addr <= 8'(i);
         pbuf_data <= 8'(i + 16);
         @(posedge sys_clk);
      end
      pbuf_we <= '0;
      cmd(CMD_PROGRAM, a, l, 8'h0);
      chk_wr(OP_PAGE_PROG, e, "program");
      chk(fl.cnt, 32 + 8 * ((l == 0) ? 256 : l), "program clocks");
      chk(fl.dat, 8'h10, "program data");
      $display("test program ended");
   endtask

   task automatic t_status();
      cmd(CMD_WRITE_STATUS, 24'h0, 9'h0, 8'h3C);
      chk_wr(OP_WRITE_STATUS, 24'h00003C, "status write");
      $display("test status write ended");
   endtask

   task automatic t_wrdis();
      cmd(CMD_WRITE_DIS, 24'h0, 9'h0, 8'h0);
      chk(fl.ops.size(), 1, "disable frames");
      chk(fl.ops[0], OP_WRITE_DIS, "disable op");
      $display("test write disable ended");
   endtask

   task automatic t_upd(input logic [2:0] c);
      cmd(c, 24'h0, 9'h0, 8'h0);
      chk_wr(OP_SECTOR_ERASE, UPDATE_ADDR, "update erase");
      $display("test update ended");
   endtask

   initial begin
      t_slave();
      t_quad(1'b0);
      t_id();
      t_erase();
      t_prog(9'h4, 24'h000310, 24'h000300);
      t_prog(9'h0, 24'h3FFFF0, 24'h1FFF00);
      t_status();
      t_wrdis();
      t_upd(CMD_REMOVE_UPD);
      t_upd(CMD_UPDATE_FAIL);
      t_quad(1'b1);
      results();
   end
endmodule // boot_flash_sequencer_bench
